// ==== shared/dlde_pkg.sv ====
// Purpose: constants and types of the five-channel descriptor dma engine
// Assumes: one clock, word-wide master port, two-word descriptors
// Notes:   descriptor word 0 = {flags, count}, word 1 = buffer address
package dlde_pkg;
   localparam int          NCH         = 5;
   localparam int          CH_W        = 3;
   localparam int          CNT_W       = 16;
   // channel roles
   localparam logic [2:0]  CH_SCSI     = 3'h0;
   localparam logic [2:0]  CH_TXA      = 3'h1;
   localparam logic [2:0]  CH_RXA      = 3'h2;
   localparam logic [2:0]  CH_TXB      = 3'h3;
   localparam logic [2:0]  CH_RXB      = 3'h4;
   // channels that always write memory (serial receive)
   localparam logic [4:0]  CH_TOMEM    = 5'h14;
   // target decode window, base value arbitrary
   localparam logic [23:0] ENG_BASE    = 24'h000080;
   localparam logic [3:0]  OFS_PTR     = 4'h0;
   localparam logic [3:0]  OFS_STAT    = 4'h4;
   localparam logic [3:0]  OFS_ADDR    = 4'h8;
   // descriptor fields
   localparam int          DESC_FLG_LSB = 16;
   localparam int          FLG_LAST    = 0;
   localparam int          FLG_TOMEM   = 1;
   localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;
   localparam logic [15:0] CNT_STEP    = 16'h0001;
   localparam logic [31:0] PTR_RST     = 32'h0000_0000;
   localparam logic [15:0] CNT_RST     = 16'h0000;

   typedef enum logic [1:0] {ST_IDLE, ST_DESC0, ST_DESC1, ST_XFER} dlde_state_t;
endpackage

// ==== design/dlde_engine.sv ====
// Purpose: five-channel descriptor list dma engine with word fifo to devices
// Assumes: synchronous active-low reset, master port acks one word per cycle
// Notes:   fixed priority, pending descriptor fetches before data
// What this block does
// [RULE1] Five independent channels each keep their channel program pointer in one shared file.
// [RULE2] A second file keeps each channel's buffer address, remaining count and flags.
// [RULE3] One 32-bit incrementer advances both program pointers and buffer addresses, one channel at a time.
// [RULE4] One 16-bit decrementer reduces the remaining count of whichever channel moves data.
// [RULE5] An exhausted buffer whose descriptor is not flagged last makes the engine fetch the next descriptor from memory by itself.
// [RULE6] Device requests are arbitrated and the winner gets a master read or write of data or descriptors.
// [RULE7] Channel zero alone carries data for the disk controller.
// [RULE8] Four channels serve the two serial ports, one per direction per port.
// [RULE9] Target accesses to the engine's window are decoded and answered, others go to the io controllers.
// [RULE10] A channel whose count is zero raises no data transfer until a new descriptor is loaded.
`timescale 1ns/1ps
module dlde_fifo
   import dlde_pkg::*;
#(
   parameter int W = 35,
   parameter int D = 16
)(
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   // count is one bit wider than the pointers so that full is distinguishable
   assign o_in_ready  = (cnt_r != (AW+1)'(D));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem_r[rd_r];

   always_ff @(posedge i_ref_clk)
   begin
      if (push)
      begin
         mem_r[wr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wr_r <= (wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1;
         if (pop)
            rd_r <= (rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module dlde_engine
   import dlde_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int DATA_W     = 32
)(
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_tgt_valid,
   input  wire logic                   i_tgt_we,
   input  wire logic [31:0]            i_tgt_addr,
   input  wire logic [31:0]            i_tgt_wdata,
   output logic                        o_tgt_ack,
   output logic                        o_tgt_eng_hit,
   output logic                        o_tgt_io_sel,
   output logic [31:0]                 o_tgt_rdata,
   output logic                        o_mst_req,
   output logic                        o_mst_we,
   output logic [31:0]                 o_mst_addr,
   output logic [DATA_W-1:0]           o_mst_wdata,
   input  wire logic                   i_mst_ack,
   input  wire logic [DATA_W-1:0]      i_mst_rdata,
   input  wire logic [NCH-1:0]         i_dev_req,
   input  wire logic [NCH-1:0][DATA_W-1:0] i_dev_wdata,
   output logic [NCH-1:0]              o_dev_wack,
   output logic                        o_dev_rvalid,
   output logic [CH_W-1:0]             o_dev_rch,
   output logic [DATA_W-1:0]           o_dev_rdata,
   input  wire logic                   i_dev_rready,
   output logic [NCH-1:0]              o_ch_done
);
   function automatic logic [CH_W-1:0] first_one(input logic [NCH-1:0] v);
      logic [CH_W-1:0] r;
      r = '0;
      for (int i = NCH - 1; i >= 0; i--)
         if (v[i])
            r = CH_W'(i);
      return r;
   endfunction

   // [RULE1] program pointer file
   logic [31:0]       ptr_r  [NCH];
   // [RULE2] live context file
   logic [31:0]       addr_r [NCH];
   logic [CNT_W-1:0]  cnt_r  [NCH];
   logic [15:0]       flg_r  [NCH];
   logic [NCH-1:0]    active_r;
   logic [NCH-1:0]    pend_r;
   dlde_state_t       state_r;
   logic [CH_W-1:0]   cur_r;
   logic [NCH-1:0]    tomem;
   logic [NCH-1:0]    xfer_ok;
   logic [31:0]       inc_in;
   logic [31:0]       inc_out;
   logic [CNT_W-1:0]  cur_cnt;
   logic [CNT_W-1:0]  dec_out;
   logic              fifo_in_ready;
   logic              fifo_push;
   logic              eng_hit;
   logic [CH_W-1:0]   tgt_ch;
   logic              tgt_ch_ok;
   logic [3:0]        tgt_ofs;
   logic              xfer_ack;

   always_comb
   begin
      for (int c = 0; c < NCH; c++)
      begin
         // [RULE7] disk channel direction from flags
         if (CH_W'(c) == CH_SCSI)
            tomem[c] = flg_r[c][FLG_TOMEM];
         // [RULE8] serial tx reads, rx writes memory
         else
            tomem[c] = CH_TOMEM[c];
         // [RULE10] zero count blocks requests
         xfer_ok[c] = i_dev_req[c] && active_r[c] && (cnt_r[c] != '0)
                      && (tomem[c] || fifo_in_ready);
      end
   end

   // [RULE3] single shared incrementer
   assign inc_in   = (state_r == ST_XFER) ? addr_r[cur_r] : ptr_r[cur_r];
   assign inc_out  = inc_in + ADDR_STEP;
   // [RULE4] single shared decrementer
   assign cur_cnt  = cnt_r[cur_r];
   assign dec_out  = cur_cnt - CNT_STEP;
   assign xfer_ack = (state_r == ST_XFER) && i_mst_ack;
   assign fifo_push = xfer_ack && !o_mst_we;

   assign eng_hit   = (i_tgt_addr[31:8] == ENG_BASE);
   assign tgt_ch    = i_tgt_addr[6:4];
   assign tgt_ch_ok = (tgt_ch < CH_W'(NCH));
   assign tgt_ofs   = i_tgt_addr[3:0];

   // [RULE6] arbitration and master sequencing
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         state_r     <= ST_IDLE;
         cur_r       <= '0;
         o_mst_req   <= 1'b0;
         o_mst_we    <= 1'b0;
         o_mst_addr  <= '0;
         o_mst_wdata <= '0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               // [RULE5] descriptor fetch goes first
               if (|pend_r)
               begin
                  cur_r      <= first_one(pend_r);
                  o_mst_req  <= 1'b1;
                  o_mst_we   <= 1'b0;
                  o_mst_addr <= ptr_r[first_one(pend_r)];
                  state_r    <= ST_DESC0;
               end
               else if (|xfer_ok)
               begin
                  cur_r       <= first_one(xfer_ok);
                  o_mst_req   <= 1'b1;
                  o_mst_we    <= tomem[first_one(xfer_ok)];
                  o_mst_addr  <= addr_r[first_one(xfer_ok)];
                  o_mst_wdata <= i_dev_wdata[first_one(xfer_ok)];
                  state_r     <= ST_XFER;
               end
            end
            ST_DESC0:
            begin
               if (i_mst_ack)
               begin
                  o_mst_addr <= inc_out;
                  state_r    <= ST_DESC1;
               end
            end
            ST_DESC1, ST_XFER:
            begin
               if (i_mst_ack)
               begin
                  o_mst_req <= 1'b0;
                  state_r   <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // channel context updates
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            ptr_r[c]  <= PTR_RST;
            addr_r[c] <= PTR_RST;
            cnt_r[c]  <= CNT_RST;
            flg_r[c]  <= '0;
         end
         active_r <= '0;
         pend_r   <= '0;
      end
      else
      begin
         if (state_r == ST_DESC0 && i_mst_ack)
         begin
            ptr_r[cur_r]  <= inc_out;
            cnt_r[cur_r]  <= i_mst_rdata[CNT_W-1:0];
            flg_r[cur_r]  <= i_mst_rdata[DESC_FLG_LSB +: 16];
            pend_r[cur_r] <= 1'b0;
         end
         if (state_r == ST_DESC1 && i_mst_ack)
         begin
            ptr_r[cur_r]    <= inc_out;
            addr_r[cur_r]   <= i_mst_rdata[31:0];
            active_r[cur_r] <= (cur_cnt != '0);
         end
         if (xfer_ack)
         begin
            addr_r[cur_r] <= inc_out;
            cnt_r[cur_r]  <= dec_out;
            // [RULE5] chain to next descriptor
            if (dec_out == '0)
            begin
               if (flg_r[cur_r][FLG_LAST])
                  active_r[cur_r] <= 1'b0;
               else
                  pend_r[cur_r] <= 1'b1;
            end
         end
         // [RULE9] engine window writes
         if (i_tgt_valid && i_tgt_we && eng_hit && tgt_ch_ok)
         begin
            if (tgt_ofs == OFS_PTR)
            begin
               ptr_r[tgt_ch]    <= i_tgt_wdata;
               pend_r[tgt_ch]   <= 1'b1;
               active_r[tgt_ch] <= 1'b0;
            end
            if (tgt_ofs == OFS_STAT)
               active_r[tgt_ch] <= 1'b0;
         end
      end
   end

   // device side strobes
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_dev_wack <= '0;
         o_ch_done  <= '0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            o_dev_wack[c] <= xfer_ack && o_mst_we && (cur_r == CH_W'(c));
            o_ch_done[c]  <= xfer_ack && (cur_r == CH_W'(c)) && (dec_out == '0)
                             && flg_r[c][FLG_LAST];
         end
      end
   end

   // [RULE9] target decode and answer
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_tgt_ack     <= 1'b0;
         o_tgt_eng_hit <= 1'b0;
         o_tgt_io_sel  <= 1'b0;
         o_tgt_rdata   <= '0;
      end
      else
      begin
         o_tgt_ack     <= i_tgt_valid;
         o_tgt_eng_hit <= i_tgt_valid && eng_hit;
         o_tgt_io_sel  <= i_tgt_valid && !eng_hit;
         o_tgt_rdata   <= '0;
         if (i_tgt_valid && !i_tgt_we && eng_hit && tgt_ch_ok)
         begin
            if (tgt_ofs == OFS_PTR)
               o_tgt_rdata <= ptr_r[tgt_ch];
            else if (tgt_ofs == OFS_STAT)
               o_tgt_rdata <= {flg_r[tgt_ch][13:0], pend_r[tgt_ch], active_r[tgt_ch], cnt_r[tgt_ch]};
            else if (tgt_ofs == OFS_ADDR)
               o_tgt_rdata <= addr_r[tgt_ch];
         end
      end
   end

   dlde_fifo #(
      .W (DATA_W + CH_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (fifo_push),
      .i_in_data   ({cur_r, i_mst_rdata}),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (o_dev_rvalid),
      .o_out_data  ({o_dev_rch, o_dev_rdata}),
      .i_out_ready (i_dev_rready)
   );

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   req_hold_a: assert property (o_mst_req && !i_mst_ack |=> o_mst_req && $stable(o_mst_addr)) // [RULE6]
      else $error("master request dropped or moved before ack");
   addr_inc_a: assert property (xfer_ack |=> addr_r[$past(cur_r)] == $past(o_mst_addr) + ADDR_STEP) // [RULE3]
      else $error("buffer address not advanced by one word");
   cnt_dec_a: assert property (xfer_ack |=> cnt_r[$past(cur_r)] == $past(cur_cnt) - CNT_STEP) // [RULE4]
      else $error("count not reduced by one");
   zero_gate_a: assert property (state_r == ST_XFER |-> cur_cnt != '0) // [RULE10]
      else $error("transfer issued on exhausted channel");
   chain_next_a: assert property (xfer_ack && cur_cnt == CNT_STEP && !flg_r[cur_r][FLG_LAST]
                                  |=> pend_r[$past(cur_r)] ##1 state_r == ST_DESC0) // [RULE5]
      else $error("exhausted buffer did not fetch next descriptor");
   desc_pair_a: assert property (state_r == ST_DESC0 && i_mst_ack
                                 |=> state_r == ST_DESC1 && o_mst_addr == $past(o_mst_addr) + ADDR_STEP) // [RULE1]
      else $error("second descriptor word not at next address");
   tx_read_a: assert property (state_r == ST_XFER && (cur_r == CH_TXA || cur_r == CH_TXB) |-> !o_mst_we) // [RULE8]
      else $error("serial transmit channel wrote memory");
   tgt_answer_a: assert property (i_tgt_valid |=> o_tgt_ack && (o_tgt_eng_hit != o_tgt_io_sel)) // [RULE9]
      else $error("target access not answered exactly once");
   fifo_room_a: assert property (state_r == ST_XFER && !o_mst_we |-> fifo_in_ready) // [RULE6]
      else $error("read issued without fifo room");
endmodule

// ==== testbench/dlde_mem_model.sv ====
// Purpose: word memory on the master port of the dma engine
// Assumes: one request at a time, ack after i_wait idle cycles
// Notes:   read data is only meaningful in the ack cycle
`timescale 1ns/1ps
module dlde_mem_model(
   input  wire logic        i_ref_clk,
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wait,
   output logic             o_ack,
   output logic [31:0]      o_rdata
);
   logic [31:0] mem [256];
   logic [31:0] rd_r;
   logic [3:0]  cnt_r;
   initial
   begin
      o_ack = 1'b0;
      rd_r = 32'h0;
      cnt_r = 4'h0;
   end
   // outside the ack cycle the data lines show garbage
   assign o_rdata = o_ack ? rd_r : ~rd_r;
   always @(posedge i_ref_clk)
   begin
      o_ack <= 1'b0;
      if (i_req && !o_ack)
      begin
         if (cnt_r >= i_wait)
         begin
            o_ack <= 1'b1;
            cnt_r <= 4'h0;
            rd_r <= mem[i_addr[9:2]];
            if (i_we)
               mem[i_addr[9:2]] <= i_wdata;
         end
         else
            cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the five-channel dma engine
// Assumes: memory model on the master port, bench plays the devices
// Notes:   buffer words hold 0x77000000 plus their own address
`timescale 1ns/1ps
module testbench;
   import dlde_pkg::*;
   logic                 clk, rst_n, tv, twe, rdy, ack, hit, io, rv;
   logic                 mreq, mwe, mack;
   logic [31:0]          ta, twd, rd, trd, maddr, mwd, mrd, drd;
   logic [NCH-1:0]       dreq, done, wack, done_seen;
   logic [NCH-1:0][31:0] dwd;
   logic [2:0]           rch;
   logic [3:0]           wt;
   logic [1:0]           hs;
   int                   bad_count, checks_done, wack_n;

   dlde_engine DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_tgt_valid(tv), .i_tgt_we(twe),
      .i_tgt_addr(ta), .i_tgt_wdata(twd), .o_tgt_ack(ack), .o_tgt_eng_hit(hit),
      .o_tgt_io_sel(io), .o_tgt_rdata(trd), .o_mst_req(mreq), .o_mst_we(mwe),
      .o_mst_addr(maddr), .o_mst_wdata(mwd), .i_mst_ack(mack), .i_mst_rdata(mrd),
      .i_dev_req(dreq), .i_dev_wdata(dwd), .o_dev_wack(wack), .o_dev_rvalid(rv),
      .o_dev_rch(rch), .o_dev_rdata(drd), .i_dev_rready(rdy), .o_ch_done(done));
   dlde_mem_model mem_i (.i_ref_clk(clk), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
      .i_wdata(mwd), .i_wait(wt), .o_ack(mack), .o_rdata(mrd));

   always #12.5 clk = ~clk;
   always @(posedge clk) done_seen <= rst_n ? (done_seen | done) : '0;
   always @(posedge clk) wack_n <= rst_n ? wack_n + $countones(wack) : 0;

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmp(logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   // one target access, answer sampled in the ack cycle, then one idle cycle
   task automatic tgt(logic we, logic [31:0] a, logic [31:0] wd);
      tv = 1'b1; twe = we; ta = a; twd = wd;
      tick();
      tv = 1'b0;
      rd = trd;
      hs = {io, hit};
      cmp(1, ack);
      tick();
   endtask
   task automatic desc(int p, logic [31:0] w0, logic [31:0] w1);
      mem_i.mem[p/4] = w0;
      mem_i.mem[p/4+1] = w1;
   endtask
   task automatic wait_done(int ch);
      for (int k = 0; k < 3000 && !done_seen[ch]; k++) tick();
      cmp(1, done_seen[ch]);
      if (!done_seen[ch]) final_report();
   endtask
   task automatic get_words(int ch, int n, logic [31:0] base);
      int got;
      got = 0;
      // head word is judged before the edge that pops it
      for (int k = 0; k < 3000 && got < n; k++)
      begin
         if (rv === 1'b1 && rdy)
         begin
            cmp(ch, {29'h0, rch});
            cmp(base + got * 4, drd);
            got++;
         end
         tick();
      end
      cmp(n, got);
      if (got != n) final_report();
   endtask

   task automatic t_decode();
      logic seen;
      seen = 1'b0;
      desc(32'h100, 32'h0, 32'h200);
      tgt(1, 32'h8030, 32'h100);
      cmp(1, hs[0]);
      tick(10);
      tgt(0, 32'h8030, 0);
      // pointer has stepped past the one descriptor it fetched
      cmp(32'h108, rd);
      dreq[3] = 1'b1;
      for (int k = 0; k < 40; k++)
      begin
         tick();
         seen |= mreq | rv;
      end
      cmp(0, seen);
      tgt(0, 32'h8034, 0);
      cmp(0, rd[15:0]);
      dreq[3] = 1'b0;
      tgt(0, 32'h1000, 0);
      cmp(2'b10, hs);
      tgt(0, 32'h800c, 0);
      cmp(32'h1, {rd[30:0], hs[0]});
      tgt(1, 32'h8050, 32'h55);
      tgt(0, 32'h8050, 0);
      cmp(32'h1, {rd[30:0], hs[0]});
      $display("decode test done");
   endtask
   task automatic t_tx();
      wt = 4'h3;
      desc(32'h110, 32'h0001_0003, 32'h200);
      tgt(1, 32'h8010, 32'h110);
      dreq[1] = 1'b1;
      get_words(1, 3, 32'h7700_0200);
      dreq[1] = 1'b0;
      wait_done(1);
      tgt(0, 32'h8018, 0);
      cmp(32'h20c, rd);
      tgt(0, 32'h8014, 0);
      cmp(0, rd[15:0]);
      $display("transmit test done");
   endtask
   task automatic t_fifo();
      wt = 4'h0;
      rdy = 1'b0;
      desc(32'h120, 32'h0001_0014, 32'h300);
      tgt(1, 32'h8030, 32'h120);
      dreq[3] = 1'b1;
      tick(200);
      cmp(1, rv);
      tgt(0, 32'h8034, 0);
      cmp(4, rd[15:0]);
      rdy = 1'b1;
      get_words(3, 20, 32'h7700_0300);
      dreq[3] = 1'b0;
      wait_done(3);
      $display("fifo test done");
   endtask
   task automatic t_rx_chain();
      wt = 4'h1;
      desc(32'h130, 32'h0000_0001, 32'h380);
      desc(32'h138, 32'h0001_0002, 32'h390);
      desc(32'h140, 32'h0003_0001, 32'h3a0);
      dwd[0] = 32'h5c5c_0001;
      dwd[2] = 32'hbeef_0002;
      tgt(1, 32'h8020, 32'h130);
      tgt(1, 32'h8000, 32'h140);
      dreq = 5'h05;
      wait_done(0);
      wait_done(2);
      dreq = 5'h00;
      // one write ack per word: one disk word and three receive words
      cmp(4, wack_n);
      cmp(32'h5c5c_0001, mem_i.mem[32'h3a0/4]);
      cmp(32'hbeef_0002, mem_i.mem[32'h380/4]);
      cmp(32'hbeef_0002, mem_i.mem[32'h390/4]);
      cmp(32'hbeef_0002, mem_i.mem[32'h394/4]);
      cmp(32'h7700_0398, mem_i.mem[32'h398/4]);
      tgt(0, 32'h8028, 0);
      cmp(32'h398, rd);
      $display("receive chain test done");
   endtask

   initial
   begin
      clk = 1'b0; rst_n = 1'b0; tv = 1'b0; twe = 1'b0; rdy = 1'b1;
      ta = 32'h0; twd = 32'h0; dreq = '0; dwd = '0; wt = 4'h0;
      bad_count = 0; checks_done = 0;
      for (int i = 0; i < 256; i++) mem_i.mem[i] = 32'h7700_0000 + i * 4;
      tick(5);
      rst_n = 1'b1;
      t_decode();
      t_tx();
      t_fifo();
      t_rx_chain();
      final_report();
   end
   initial
   begin
      #2000000;
      bad_count++;
      final_report();
   end
endmodule
